// *** rtl/pphs_defines.vh ***
`ifndef PPHS_DEFINES_VH
`define PPHS_DEFINES_VH
// Register byte addresses
`define PPHS_ADDR_CONTROL 8'h00
`define PPHS_ADDR_STATUS 8'h04
`define PPHS_ADDR_MASK 8'h08
`define PPHS_ADDR_DATA 8'h0C
`define PPHS_ADDR_ICT 8'h10
// Control register fields
`define PPHS_CT_MODE_LSB 0
`define PPHS_CT_MODE_MSB 2
`define PPHS_CT_OVR_ACK 3
`define PPHS_CT_OVR_BUSY 4
`define PPHS_CT_F_ACK 5
`define PPHS_CT_F_BUSY 6
`define PPHS_CT_DMASEL 7
`define PPHS_CT_DMASK 8
`define PPHS_CT_CHAN 9
`define PPHS_CT_ACKNOWLEDGE_PULSE_LENGTH_LSB 16
`define PPHS_CT_ACKNOWLEDGE_PULSE_LENGTH_MSB 23
`define PPHS_CT_RESET 32'h0001_0000
// Mode encodings
`define PPHS_MODE_NONE 3'h0
`define PPHS_MODE_COMPAT 3'h1
// Status register fields
`define PPHS_ST_EDGE_LSB 0
`define PPHS_ST_LEVEL_LSB 8
`define PPHS_ST_REQ 14
// Mask register: 8 edge masks, plus command and init condition masks
`define PPHS_MK_CMD 8
`define PPHS_MK_INIT 9
// Interrupt control register bit
`define PPHS_ICT_DATA 0
`endif

// *** rtl/pphs_edge_det.v ***
module pphs_edge_det (
  input wire clk,
  input wire resetn,
  input wire enable,
  input wire [3:0] level,
  input wire [7:0] clear,
  output reg [7:0] seen
);
  reg [3:0] prev;
  genvar i;
  always @(posedge clk) begin
    if (!resetn) begin
      prev <= 4'h0;
    end else begin
      prev <= level;
    end
  end
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_edge
      // Sticky rise and fall bits, an edge beats a clear
      always @(posedge clk) begin
        if (!resetn) begin
          seen[2*i] <= 1'b0;
          seen[2*i+1] <= 1'b0;
        end else begin
          if (enable && level[i] && !prev[i]) begin
            seen[2*i] <= 1'b1;
          end else if (clear[2*i]) begin
            seen[2*i] <= 1'b0;
          end
          if (enable && !level[i] && prev[i]) begin
            seen[2*i+1] <= 1'b1;
          end else if (clear[2*i+1]) begin
            seen[2*i+1] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule

// *** rtl/pphs_ack_timer.v ***
module pphs_ack_timer (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [7:0] length,
  output reg active,
  output reg done
);
  reg [7:0] count;
  always @(posedge clk) begin
    if (!resetn) begin
      active <= 1'b0;
      done <= 1'b0;
      count <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        count <= (length == 8'h00) ? 8'h01 : length;
      end else if (active) begin
        if (count == 8'h01) begin
          active <= 1'b0;
          done <= 1'b1;
        end
        count <= count - 8'h01;
      end
    end
  end
endmodule

// *** rtl/pphs_port.v ***
// Chosen here: the register offsets and the plain strobed port.
`include "pphs_defines.vh"

// Summary of operation
// - Mode field selects handshake protocol
// - Override bits drive ack and busy directly
// - Mode zero: levels only, no edges
// - Enabled edges and conditions raise control interrupt
// - Mode one gives automatic forward handshake
// - Strobe true edge sets busy, request
// - Latch strobe pulses on host strobe in mode one
// - Data read starts programmed acknowledge pulse
// - Busy drops when acknowledge pulse ends
// - Autofeed level readable in status
// - Ack length counts clocks, 1 to 255
// - Masked, non-DMA request sets data interrupt
// - DMA select routes request to channel
// - Eight edge status bits in status
// - Edges use uninverted pin level
// - Transfer clears pending request
// - Data address drives external latch enables
module pphs_port (
  input wire clk,
  input wire resetn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire host_strobe_in,
  input wire host_autofeed_in,
  input wire host_select_in,
  input wire host_restart_in,
  input wire ecp_command_cond,
  input wire device_init_cond,
  input wire dma_ack,
  output reg peripheral_ack_out,
  output reg peripheral_busy_out,
  output reg external_latch_strobe,
  output reg latch_output_enable,
  output reg latch_write_enable,
  output reg port_control_interrupt,
  output reg data_interrupt,
  output reg dma_request,
  output reg dma_channel_select,
  output reg dma_to_device,
  output reg [2:0] port_protocol_select
);
  reg [31:0] port_control_reg;
  reg [9:0] irq_mask;
  reg transfer_request_status;
  reg auto_busy;
  reg prev_strobe;
  reg data_irq_flag;
  wire [7:0] edge_seen;
  wire ack_active;
  wire ack_done;
  wire [3:0] pins;
  wire compat;
  wire no_mode;
  wire ack_software_override;
  wire busy_software_override;
  wire forced_acknowledge_bit;
  wire forced_busy_bit;
  wire dma_request_select;
  wire data_interrupt_mask;
  wire [7:0] acknowledge_pulse_length;
  wire data_read;
  wire data_write;
  wire host_read;
  wire strobe_rise;
  wire [7:0] edge_clear;
  wire [7:0] port_status_reg_edges;
  reg [31:0] next_rdata;

  assign pins = {host_restart_in, host_select_in, host_autofeed_in, host_strobe_in};
  assign compat = port_control_reg[`PPHS_CT_MODE_MSB:`PPHS_CT_MODE_LSB] == `PPHS_MODE_COMPAT;
  assign no_mode = port_control_reg[`PPHS_CT_MODE_MSB:`PPHS_CT_MODE_LSB] == `PPHS_MODE_NONE;
  assign ack_software_override = port_control_reg[`PPHS_CT_OVR_ACK];
  assign busy_software_override = port_control_reg[`PPHS_CT_OVR_BUSY];
  assign forced_acknowledge_bit = port_control_reg[`PPHS_CT_F_ACK];
  assign forced_busy_bit = port_control_reg[`PPHS_CT_F_BUSY];
  assign dma_request_select = port_control_reg[`PPHS_CT_DMASEL];
  assign data_interrupt_mask = port_control_reg[`PPHS_CT_DMASK];
  assign acknowledge_pulse_length =
    port_control_reg[`PPHS_CT_ACKNOWLEDGE_PULSE_LENGTH_MSB:`PPHS_CT_ACKNOWLEDGE_PULSE_LENGTH_LSB];
  assign data_read = rd && (addr == `PPHS_ADDR_DATA);
  assign data_write = wr && (addr == `PPHS_ADDR_DATA);
  assign host_read = data_read || (dma_ack && dma_request);
  assign strobe_rise = host_strobe_in && !prev_strobe;
  assign edge_clear = (wr && addr == `PPHS_ADDR_STATUS) ? wdata[7:0] : 8'h00;
  assign port_status_reg_edges = edge_seen;

  pphs_edge_det u_edge (
    .clk(clk),
    .resetn(resetn),
    .enable(!no_mode),
    .level(pins),
    .clear(edge_clear),
    .seen(edge_seen)
  );

  pphs_ack_timer u_ack (
    .clk(clk),
    .resetn(resetn),
    .start(compat && host_read),
    .length(acknowledge_pulse_length),
    .active(ack_active),
    .done(ack_done)
  );

  // Register writes
  always @(posedge clk) begin
    if (!resetn) begin
      port_control_reg <= `PPHS_CT_RESET;
      irq_mask <= 10'h000;
    end else if (wr) begin
      if (addr == `PPHS_ADDR_CONTROL) begin
        port_control_reg <= wdata;
      end
      if (addr == `PPHS_ADDR_MASK) begin
        irq_mask <= wdata[9:0];
      end
    end
  end

  // Compatibility handshake state
  always @(posedge clk) begin
    if (!resetn) begin
      prev_strobe <= 1'b0;
      transfer_request_status <= 1'b0;
      auto_busy <= 1'b0;
      data_irq_flag <= 1'b0;
    end else begin
      prev_strobe <= host_strobe_in;
      if (compat && strobe_rise) begin
        transfer_request_status <= 1'b1;
      end else if (host_read) begin
        transfer_request_status <= 1'b0;
      end
      if (compat && strobe_rise) begin
        auto_busy <= 1'b1;
      end else if (ack_done || !compat) begin
        auto_busy <= 1'b0;
      end
      if (compat && strobe_rise && data_interrupt_mask && !dma_request_select) begin
        data_irq_flag <= 1'b1;
      end else if (wr && addr == `PPHS_ADDR_ICT && wdata[`PPHS_ICT_DATA]) begin
        data_irq_flag <= 1'b0;
      end
    end
  end

  // Registered outputs
  always @(posedge clk) begin
    if (!resetn) begin
      peripheral_ack_out <= 1'b0;
      peripheral_busy_out <= 1'b0;
      external_latch_strobe <= 1'b0;
      latch_output_enable <= 1'b0;
      latch_write_enable <= 1'b0;
      port_control_interrupt <= 1'b0;
      data_interrupt <= 1'b0;
      dma_request <= 1'b0;
      dma_channel_select <= 1'b0;
      dma_to_device <= 1'b0;
      port_protocol_select <= 3'h0;
      rdata <= 32'h0000_0000;
    end else begin
      peripheral_ack_out <= ack_software_override ? forced_acknowledge_bit :
        ack_active;
      peripheral_busy_out <= busy_software_override ? forced_busy_bit :
        ((auto_busy && !ack_done) || (compat && strobe_rise));
      external_latch_strobe <= compat && host_strobe_in;
      latch_output_enable <= host_read;
      latch_write_enable <= data_write;
      port_control_interrupt <= |(edge_seen & irq_mask[7:0]) ||
        (ecp_command_cond && irq_mask[`PPHS_MK_CMD]) ||
        (device_init_cond && irq_mask[`PPHS_MK_INIT]);
      data_interrupt <= data_irq_flag;
      dma_request <= dma_request_select && transfer_request_status &&
        !(dma_ack && dma_request);
      dma_channel_select <= port_control_reg[`PPHS_CT_CHAN];
      dma_to_device <= !compat && !no_mode;
      port_protocol_select <=
        port_control_reg[`PPHS_CT_MODE_MSB:`PPHS_CT_MODE_LSB];
      rdata <= next_rdata;
    end
  end

  // Read mux, data window returns zero since the latch answers externally
  always @* begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `PPHS_ADDR_CONTROL: next_rdata = port_control_reg;
        `PPHS_ADDR_STATUS: begin
          next_rdata[7:0] = port_status_reg_edges;
          next_rdata[11:8] = pins;
          next_rdata[12] = peripheral_busy_out;
          next_rdata[13] = peripheral_ack_out;
          next_rdata[`PPHS_ST_REQ] = transfer_request_status;
        end
        `PPHS_ADDR_MASK: next_rdata[9:0] = irq_mask;
        `PPHS_ADDR_ICT: next_rdata[`PPHS_ICT_DATA] = data_irq_flag;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// *** verification/pphs_host_model.sv ***
module pphs_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic busy,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial strobe = 1'b0;
  // One strobe per request, only while the port is not busy
  always @(posedge clk) strobe <= go && !busy && !strobe;
endmodule

// *** verification/pphs_port_checker.sv ***
module pphs_port_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic host_strobe_in,
  input wire logic dma_ack,
  input wire logic peripheral_ack_out,
  input wire logic peripheral_busy_out,
  input wire logic external_latch_strobe,
  input wire logic latch_output_enable,
  input wire logic latch_write_enable,
  input wire logic data_interrupt,
  input wire logic dma_request,
  input wire logic [2:0] port_protocol_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ct;
  logic [8:0] n;
  wire m1 = port_protocol_select == 3'h1;
  // Control shadow and ack width
  always @(posedge clk) begin
    if (!resetn) ct <= 32'h0001_0000;
    else if (wr && addr == 8'h00) ct <= wdata;
    n <= peripheral_ack_out ? n + 9'h001 : 9'h000;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_ack_end;
    peripheral_ack_out && peripheral_busy_out && m1 && ct[4:3] == 2'b00 ##1 !peripheral_ack_out;
  endsequence
  a_strobe_busy: assert property ($rose(host_strobe_in) && m1 && !ct[4]
    |-> ##[1:2] peripheral_busy_out) else $error("busy late");
  a_latch_copy: assert property (m1 ##1 m1
    |-> external_latch_strobe == $past(host_strobe_in)) else $error("latch");
  a_ack_width: assert property ($fell(peripheral_ack_out) && !ct[3]
    |-> n == (ct[23:16] == 8'h00 ? 9'h001 : {1'b0, ct[23:16]})) else $error("ack len");
  a_busy_end: assert property (s_ack_end
    |-> !peripheral_busy_out) else $error("busy end");
  a_ovr_ack: assert property ($stable(ct) && ct[3]
    |=> peripheral_ack_out == $past(ct[5])) else $error("ovr ack");
  a_ovr_busy: assert property ($stable(ct) && ct[4]
    |=> peripheral_busy_out == $past(ct[6])) else $error("ovr busy");
  a_read_oe: assert property ((rd && addr == 8'h0C) || dma_ack
    |=> latch_output_enable) else $error("oe");
  a_write_we: assert property (wr && addr == 8'h0C |=> latch_write_enable)
    else $error("we");
  a_idle_rdata: assert property (!$past(rd) || $past(addr) == 8'h0C
    |-> rdata == 32'h0000_0000) else $error("rdata");
  a_dma_route: assert property ($rose(dma_request) |-> ct[7])
    else $error("dma");
  a_irq_route: assert property ($rose(data_interrupt) |-> ct[8] && !ct[7])
    else $error("irq");
endmodule
bind pphs_port pphs_port_checker pphs_port_checker_inst (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .host_strobe_in(host_strobe_in), .dma_ack(dma_ack),
  .peripheral_ack_out(peripheral_ack_out), .peripheral_busy_out(peripheral_busy_out),
  .external_latch_strobe(external_latch_strobe), .latch_output_enable(latch_output_enable),
  .latch_write_enable(latch_write_enable), .data_interrupt(data_interrupt),
  .dma_request(dma_request), .port_protocol_select(port_protocol_select)
);

// *** verification/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, dma_ack = 1'b0, go = 1'b0;
  logic host_autofeed_in = 1'b0, host_select_in = 1'b0, host_restart_in = 1'b0;
  logic ecp_command_cond = 1'b0, device_init_cond = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, got, ct;
  logic [2:0] port_protocol_select;
  logic host_strobe_in, peripheral_ack_out, peripheral_busy_out, external_latch_strobe;
  logic latch_output_enable, latch_write_enable, port_control_interrupt, data_interrupt;
  logic dma_request, dma_channel_select, dma_to_device;
  int errors = 0, samples_checked = 0, cyc = 0, w = 0, len;
  int q[$];
  initial forever #4 clk = ~clk;
  pphs_port pphs_port_inst (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .host_strobe_in(host_strobe_in), .host_autofeed_in(host_autofeed_in),
    .host_select_in(host_select_in), .host_restart_in(host_restart_in),
    .ecp_command_cond(ecp_command_cond), .device_init_cond(device_init_cond),
    .dma_ack(dma_ack), .peripheral_ack_out(peripheral_ack_out),
    .peripheral_busy_out(peripheral_busy_out), .external_latch_strobe(external_latch_strobe),
    .latch_output_enable(latch_output_enable), .latch_write_enable(latch_write_enable),
    .port_control_interrupt(port_control_interrupt), .data_interrupt(data_interrupt),
    .dma_request(dma_request), .dma_channel_select(dma_channel_select),
    .dma_to_device(dma_to_device), .port_protocol_select(port_protocol_select)
  );
  pphs_host_model pphs_host_model_inst (.clk(clk), .go(go), .busy(peripheral_busy_out),
    .strobe(host_strobe_in));
  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdata;
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    if (s == 0) go <= 1'b1;
    else dma_ack <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    dma_ack <= 1'b0;
    @(negedge clk);
  endtask
  // Ack width model and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      errors++;
      finish_test();
    end
    if (peripheral_ack_out === 1'b1) w <= w + 1;
    else if (w > 0) begin
      if (q.size() > 0) chk(w, q.pop_front());
      w <= 0;
    end
  end
  initial begin
    len = $urandom(31833);
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rreg(8'h00);
    chk(got, 32'h0001_0000);
    rreg(8'h20);
    chk(got, 32'h0000_0000);
    @(posedge clk);
    host_autofeed_in <= 1'($urandom);
    pulse(0);
    tick(3);
    rreg(8'h04);
    chk(got, {22'h0, host_autofeed_in, 9'h000});
    for (int i = 0; i < 3; i++) begin
      len = (i == 0) ? 1 : (i == 1) ? 255 : 63 + $urandom % 60;
      ct = {8'h00, 8'(len), 6'h00, i[0], 1'b1, i == 2, 4'h0, 3'h1};
      wreg(8'h00, ct);
      wreg(8'h08, 32'h0000_0001);
      wreg(8'h04, 32'h0000_00ff);
      pulse(0);
      tick(3);
      chk(peripheral_busy_out, 1'b1);
      chk({dma_request, data_interrupt, dma_channel_select}, {i == 2, i != 2, i[0]});
      chk(port_control_interrupt, 1'b1);
      rreg(8'h04);
      chk(got, {17'h0, 3'b101, 2'b00, host_autofeed_in, 1'b0, 8'h03});
      wreg(8'h04, 32'h0000_00ff);
      tick(1);
      chk(port_control_interrupt, 1'b0);
      q.push_back(len);
      if (i == 2) pulse(1);
      else rreg(8'h0C);
      for (int k = 0; k < 300 && peripheral_busy_out !== 1'b0; k++) tick(0);
      rreg(8'h04);
      chk({got[14:12], dma_request}, 4'h0);
      wreg(8'h10, 32'h0000_0001);
      tick(1);
      chk(data_interrupt, 1'b0);
    end
    wreg(8'h00, 32'h0001_0079);
    tick(1);
    chk({peripheral_ack_out, peripheral_busy_out, port_protocol_select}, 5'h19);
    wreg(8'h00, 32'h0001_0019);
    pulse(0);
    tick(3);
    chk({peripheral_ack_out, peripheral_busy_out}, 2'b00);
    wreg(8'h08, 32'h0000_0300);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      {device_init_cond, ecp_command_cond} <= 2'b01 << k;
      tick(2);
      chk(port_control_interrupt, 1'b1);
    end
    wreg(8'h00, 32'h0001_0002);
    tick(1);
    chk({dma_to_device, port_protocol_select}, 4'hA);
    wreg(8'h0C, $urandom);
    chk(q.size(), 0);
    finish_test();
  end
endmodule
